//--- hdl/srsc_pkg.sv
// constants, types and behaviour list for the system reset source controller
//==============================================================================
// How it works
// - reset halts the core, reinitialises registers, forces ports, disables interrupts and timers.
// - data memory is untouched by reset; only the stack pointer is reset.
// - in reset port latches read all ones, open drain; weak pull-ups always on.
// - power-on and supply-monitor resets drive the reset pin low throughout reset.
// - on leaving reset clear program counter, pick internal oscillator, fetch at zero.
// - after any reset the watchdog is enabled, ticking at system clock over twelve.
// - at power-up hold reset and pin low until supply is good, then delay.
// - power-on and supply-monitor exits set the power-on flag; any other reset clears it.
// - only power-on reset turns the supply monitor on; other resets leave it.
// - supply below threshold drives pin low and holds reset until it recovers.
// - a flash erase or write with the monitor off causes a flash error reset.
// - monitor enable is control bit 7; no reset unless also selected.
// - supply status bit 6 reads 1 above threshold; bits 5-0 read zero.
// - a low reset pin resets the device; pin flag set on exit.
// - clock stuck beyond 100 us resets; its flag reads 1 only after that.
// - writing the clock-loss flag bit enables or disables the detector.
// - clock-loss and comparator resets leave the reset pin undriven.
// - comparator enable bit selects comparator reset; reads back as its cause flag.
// - a low comparator output, plus below minus, puts the device in reset.
// - enable bits read back through the enable view for read-modify-write.
// - cause bits: pin 0, power 1, clock 2, watchdog 3, soft 4, comp 5, flash 6.
package srsc_pkg;

  localparam int          ADDR_W          = 12;
  // printed offsets are register indices; byte address is four times the index
  localparam logic [9:0]  IDX_SUPPLY_CTRL = 10'h0FF;
  localparam logic [9:0]  IDX_RESET_SRC   = 10'h0EF;
  localparam logic [9:0]  IDX_RESET_ENA   = 10'h0EE;
  localparam logic [ADDR_W-1:0] ADDR_SUPPLY_CTRL = {IDX_SUPPLY_CTRL, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_RESET_SRC   = {IDX_RESET_SRC, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_RESET_ENA   = {IDX_RESET_ENA, 2'b00};

  localparam int BIT_MON_ENABLE = 7;
  localparam int BIT_SUPPLY_OK  = 6;
  localparam int BIT_PIN        = 0;
  localparam int BIT_POWER_ON   = 1;
  localparam int BIT_CLK_LOSS   = 2;
  localparam int BIT_SOFT       = 4;
  localparam int BIT_COMP       = 5;

  localparam logic [7:0]  PORT_RESET_VALUE = 8'hFF;
  localparam logic [15:0] RESET_VECTOR     = 16'h0000;
  localparam logic [3:0]  WDT_DIV_LAST     = 4'hB;
  // synchroniser reset levels: clock monitor, comparator, pin, supply
  localparam logic [3:0]  SYNC_RESET       = 4'b0110;

  localparam int CLK_PERIOD_NS     = 50;
  localparam int CLK_LOSS_US       = 100;
  localparam int RESET_DELAY_US    = 40;
  localparam int POR_DELAY_US      = 300;
  localparam int CLK_LOSS_CYC      = (CLK_LOSS_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_DELAY_CYC   = (RESET_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POR_DELAY_CYC     = (POR_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    ST_POR   = 2'b00,
    ST_HOLD  = 2'b01,
    ST_DELAY = 2'b10,
    ST_RUN   = 2'b11
  } srsc_state_t;

  typedef struct packed {
    logic unused;
    logic flashFault;
    logic comparator;
    logic software;
    logic watchdog;
    logic clockLoss;
    logic powerOn;
    logic pin;
  } srsc_cause_t;

  typedef struct packed {
    logic haltCpu;
    logic sfrInit;
    logic intDisable;
    logic timerDisable;
    logic stackPtrReset;
    logic pcClear;
    logic clkSelInternal;
  } srsc_core_ctrl_t;

endpackage

//--- hdl/srsc_top.sv
// system reset source controller with apb register slave
`timescale 1ns/100ps
module srsc_top #(
  parameter int unsigned PorDelayCycles = srsc_pkg::POR_DELAY_CYC
) (
  input  wire logic                        clk_sys,
  input  wire logic                        rst_b,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [srsc_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                 pwdata,
  input  wire logic [3:0]                  pstrb,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        supplyAbove,
  input  wire logic                        resetPinIn,
  output logic                             resetPinOut,
  output logic                             resetPinOe,
  input  wire logic                        comparatorOut,
  input  wire logic                        clockMonitor,
  input  wire logic                        watchdogTimeout,
  input  wire logic                        watchdogDisable,
  input  wire logic                        flashWriteReq,
  output logic                             sysRst_b,
  output srsc_pkg::srsc_core_ctrl_t        coreCtrl,
  output logic [15:0]                      fetchAddr,
  output logic [7:0]                       portLatch,
  output logic                             portOpenDrain,
  output logic                             weakPullupEn,
  output logic                             watchdogEnable,
  output logic                             watchdogTick
);
  import srsc_pkg::*;

  //============================================================================
  // input synchronisers
  logic [3:0]  syncRaw;
  logic [3:0]  syncMeta;
  logic [3:0]  syncOut;
  logic        supplyOk;
  logic        pinLevel;
  logic        compLevel;
  logic        clkMonLevel;
  logic        clkMonPrev;

  assign syncRaw = {clockMonitor, comparatorOut, resetPinIn, supplyAbove};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          syncMeta[gi] <= SYNC_RESET[gi];
          syncOut[gi]  <= SYNC_RESET[gi];
        end else begin
          syncMeta[gi] <= syncRaw[gi];
          syncOut[gi]  <= syncMeta[gi];
        end
      end
    end
  endgenerate

  assign supplyOk    = syncOut[0];
  assign pinLevel    = syncOut[1];
  assign compLevel   = syncOut[2];
  assign clkMonLevel = syncOut[3];

  //============================================================================
  // registers and state
  srsc_state_t state;
  srsc_state_t next_state;
  logic [15:0] delayCnt;
  logic [15:0] next_delayCnt;
  srsc_cause_t pending;
  srsc_cause_t next_pending;
  srsc_cause_t causeFlags;
  srsc_cause_t srcVec;
  logic        monEnable;
  logic        monSelect;
  logic        clkLossEnable;
  logic        compEnable;
  logic [15:0] clkIdleCnt;
  logic [2:0]  pinMaskDly;
  logic [3:0]  wdtDiv;
  logic        vmSrc;
  logic        pinSrc;
  logic        clkSrc;
  logic        compSrc;
  logic        levelActive;
  logic        apbWrite;
  logic        releasing;
  logic        next_pinDrive;

  //============================================================================
  // apb slave, zero wait states
  function automatic logic regHit(input logic [ADDR_W-1:0] addr);
    regHit = (addr == ADDR_SUPPLY_CTRL) || (addr == ADDR_RESET_SRC) || (addr == ADDR_RESET_ENA);
  endfunction

  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !regHit(paddr);
  assign apbWrite = psel && penable && pwrite && pstrb[0] && regHit(paddr);

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= 32'h0000_0000;
      if (paddr == ADDR_SUPPLY_CTRL) begin
        prdata[BIT_MON_ENABLE] <= monEnable;
        prdata[BIT_SUPPLY_OK]  <= supplyOk;
      end else if (paddr == ADDR_RESET_SRC) begin
        prdata[7:0] <= {1'b0, causeFlags[6:0]};
      end else if (paddr == ADDR_RESET_ENA) begin
        prdata[BIT_POWER_ON] <= monSelect;
        prdata[BIT_CLK_LOSS] <= clkLossEnable;
        prdata[BIT_COMP]     <= compEnable;
      end
    end
  end

  //============================================================================
  // software controls; only power-on reset forces the monitor on
  assign releasing = (state == ST_DELAY) && (next_state == ST_RUN);

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      monEnable <= 1'b1;
      monSelect <= 1'b1;
    end else if (apbWrite && paddr == ADDR_SUPPLY_CTRL) begin
      monEnable <= pwdata[BIT_MON_ENABLE];
    end else if (apbWrite && paddr == ADDR_RESET_SRC) begin
      monSelect <= pwdata[BIT_POWER_ON];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      clkLossEnable <= 1'b0;
      compEnable    <= 1'b0;
    end else if (apbWrite && paddr == ADDR_RESET_SRC) begin
      clkLossEnable <= pwdata[BIT_CLK_LOSS];
      compEnable    <= pwdata[BIT_COMP];
    end else if (releasing) begin
      // cleared only at release so a comparator reset holds until the input recovers
      clkLossEnable <= 1'b0;
      compEnable    <= 1'b0;
    end
  end

  //============================================================================
  // missing clock one-shot on the monitored clock level
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      clkMonPrev <= 1'b0;
      clkIdleCnt <= 16'h0000;
    end else begin
      clkMonPrev <= clkMonLevel;
      if (clkMonLevel != clkMonPrev) begin
        clkIdleCnt <= 16'h0000;
      end else if (clkIdleCnt < 16'(CLK_LOSS_CYC)) begin
        clkIdleCnt <= clkIdleCnt + 16'h0001;
      end
    end
  end

  //============================================================================
  // reset sources
  // own pin drive reads back low for a few cycles; mask it so it is no pin reset
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pinMaskDly <= 3'b111;
    end else begin
      pinMaskDly <= {pinMaskDly[1:0], resetPinOe};
    end
  end

  assign vmSrc   = monEnable && monSelect && !supplyOk;
  assign pinSrc  = !pinLevel && !resetPinOe && (pinMaskDly == 3'b000);
  assign clkSrc  = clkLossEnable && (clkIdleCnt >= 16'(CLK_LOSS_CYC));
  assign compSrc = compEnable && !compLevel;
  assign levelActive = vmSrc || pinSrc || clkSrc || compSrc;

  always_comb begin
    srcVec            = '0;
    srcVec.pin        = pinSrc;
    srcVec.powerOn    = vmSrc;
    srcVec.clockLoss  = clkSrc;
    srcVec.watchdog   = watchdogTimeout;
    srcVec.software   = apbWrite && (paddr == ADDR_RESET_SRC) && pwdata[BIT_SOFT];
    srcVec.comparator = compSrc;
    srcVec.flashFault = flashWriteReq && !monEnable;
  end

  //============================================================================
  // reset sequencer
  always_comb begin
    next_state    = state;
    next_delayCnt = delayCnt;
    next_pending  = pending;
    unique case (state)
      ST_POR: begin
        next_pending         = '0;
        next_pending.powerOn = 1'b1;
        if (supplyOk) begin
          next_state    = ST_DELAY;
          next_delayCnt = 16'(PorDelayCycles);
        end
      end
      ST_RUN: begin
        if (srcVec != '0) begin
          next_state   = ST_HOLD;
          next_pending = srcVec;
        end
      end
      ST_HOLD: begin
        next_pending = srsc_cause_t'(pending | srcVec);
        if (!levelActive) begin
          next_state    = ST_DELAY;
          next_delayCnt = 16'(RESET_DELAY_CYC);
        end
      end
      ST_DELAY: begin
        next_pending = srsc_cause_t'(pending | srcVec);
        if (levelActive) begin
          next_state = ST_HOLD;
        end else if (delayCnt == 16'h0000) begin
          next_state = ST_RUN;
        end else begin
          next_delayCnt = delayCnt - 16'h0001;
        end
      end
    endcase
  end

  assign next_pinDrive = (next_state != ST_RUN) && next_pending.powerOn;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state    <= ST_POR;
      delayCnt <= 16'h0000;
      pending  <= '0;
    end else begin
      state    <= next_state;
      delayCnt <= next_delayCnt;
      pending  <= next_pending;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      causeFlags <= '0;
    end else if (releasing) begin
      causeFlags <= pending;
    end
  end

  //============================================================================
  // outputs to core, ports, pin and watchdog
  assign resetPinOut = 1'b0;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      resetPinOe <= 1'b1;
      sysRst_b   <= 1'b0;
      coreCtrl   <= '1;
    end else begin
      resetPinOe              <= next_pinDrive;
      sysRst_b                <= (next_state == ST_RUN);
      coreCtrl.haltCpu        <= (next_state != ST_RUN);
      coreCtrl.sfrInit        <= (next_state != ST_RUN);
      coreCtrl.intDisable     <= (next_state != ST_RUN);
      coreCtrl.timerDisable   <= (next_state != ST_RUN);
      // memory has no clear path at all; the stack is lost only via its pointer
      coreCtrl.stackPtrReset  <= (next_state != ST_RUN);
      coreCtrl.pcClear        <= releasing;
      coreCtrl.clkSelInternal <= releasing;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      fetchAddr     <= RESET_VECTOR;
      portLatch     <= PORT_RESET_VALUE;
      portOpenDrain <= 1'b1;
      weakPullupEn  <= 1'b1;
    end else begin
      if (next_state != ST_RUN) begin
        fetchAddr <= RESET_VECTOR;
        portLatch <= PORT_RESET_VALUE;
      end
      portOpenDrain <= (next_state != ST_RUN);
      weakPullupEn  <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      watchdogEnable <= 1'b1;
      wdtDiv         <= 4'h0;
      watchdogTick   <= 1'b0;
    end else begin
      if (next_state != ST_RUN) begin
        watchdogEnable <= 1'b1;
        wdtDiv         <= 4'h0;
      end else begin
        if (watchdogDisable) begin
          watchdogEnable <= 1'b0;
        end
        wdtDiv <= (wdtDiv == WDT_DIV_LAST) ? 4'h0 : wdtDiv + 4'h1;
      end
      watchdogTick <= watchdogEnable && (state == ST_RUN) && (wdtDiv == WDT_DIV_LAST);
    end
  end

  //============================================================================
  // assertions
  a_por_pin_low: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state == ST_POR) |-> resetPinOe)
    else $error("pin not driven during power-on reset");

  a_other_pin_free: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state != ST_POR && !pending.powerOn && !srcVec.powerOn) |=> !resetPinOe)
    else $error("pin driven for non power reset");

  a_por_flag_set: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (releasing && pending.powerOn) |=> causeFlags.powerOn && (state == ST_RUN))
    else $error("power-on flag not set at release");

  a_mon_kept: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state != ST_RUN) |=> $stable(monEnable))
    else $error("monitor enable changed by reset");

  a_vm_holds: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state == ST_RUN && monEnable && monSelect && !supplyOk) |=> (state == ST_HOLD) && resetPinOe && !sysRst_b)
    else $error("supply loss did not reset");

  a_flash_err: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state == ST_RUN && flashWriteReq && !monEnable) |=> (state == ST_HOLD) && pending.flashFault)
    else $error("flash write with monitor off not reset");

  a_clk_loss: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state == ST_RUN && clkLossEnable && clkMonLevel == clkMonPrev && clkIdleCnt == 16'(CLK_LOSS_CYC - 1))
    |=> ##1 (state == ST_HOLD) && pending.clockLoss)
    else $error("clock loss timeout missed");

  a_comp_reset: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state == ST_RUN && compEnable && !compLevel) |=> pending.comparator && !sysRst_b)
    else $error("comparator low did not reset");

  a_hold_level: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state == ST_HOLD && levelActive) |=> (state == ST_HOLD) [*1] ##0 !coreCtrl.pcClear)
    else $error("reset released with source active");

  a_core_halt: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state != ST_RUN) |-> coreCtrl.haltCpu && (portLatch == PORT_RESET_VALUE) && weakPullupEn)
    else $error("core or ports not held in reset");

  a_wdt_on: assert property (@(posedge clk_sys) disable iff (!rst_b)
    $rose(state == ST_RUN) |-> watchdogEnable && coreCtrl.pcClear && (fetchAddr == RESET_VECTOR))
    else $error("exit state wrong");

endmodule

//--- tb/srsc_far_side.sv
// far-side model: reset pin wire, supply rail, comparator and monitored clock
`timescale 1ns/100ps
module srsc_far_side (
  input  wire logic clk_sys,
  input  wire logic extPinLow,
  input  wire logic supplyGood,
  input  wire logic compLow,
  input  wire logic clockStuck,
  input  wire logic resetPinOut,
  input  wire logic resetPinOe,
  output logic      supplyAbove,
  output logic      resetPinIn,
  output logic      comparatorOut,
  output logic      clockMonitor
);
  logic [1:0] divCnt;
  //==========================================================================
  // pin and analog levels
  // open drain with pull-up: low when the block or the outside pulls it
  assign resetPinIn    = ((resetPinOe && !resetPinOut) || extPinLow) ? 1'b0 : 1'b1;
  assign supplyAbove   = supplyGood;
  // low output means plus input below minus input
  assign comparatorOut = !compLow;
  //==========================================================================
  // monitored clock, slow so the synchroniser sees every level
  initial begin
    divCnt       = 2'd0;
    clockMonitor = 1'b0;
  end
  always @(posedge clk_sys) begin
    divCnt <= divCnt + 2'd1;
    if (!clockStuck && divCnt == 2'd3) begin
      clockMonitor <= !clockMonitor;
    end
  end
endmodule

//--- tb/srsc_top_tb.sv
// self-checking bench for the system reset source controller
`timescale 1ns/100ps
module srsc_top_tb;
  import srsc_pkg::*;
  localparam int POR_CYC = 20;
  logic clk_sys, rst_b, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic supplyAbove, resetPinIn, resetPinOut, resetPinOe, comparatorOut, clockMonitor;
  logic watchdogTimeout, flashWriteReq, sysRst_b, portOpenDrain, weakPullupEn, watchdogEnable, watchdogTick;
  logic extPinLow, supplyGood, compLow, clockStuck, watchdogDisable;
  srsc_core_ctrl_t coreCtrl;
  logic [15:0] fetchAddr;
  logic [7:0] portLatch;
  int n_errors, samples_checked;
  srsc_top #(.PorDelayCycles(POR_CYC)) dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .supplyAbove(supplyAbove), .resetPinIn(resetPinIn), .resetPinOut(resetPinOut),
    .resetPinOe(resetPinOe), .comparatorOut(comparatorOut), .clockMonitor(clockMonitor),
    .watchdogTimeout(watchdogTimeout), .watchdogDisable(watchdogDisable), .flashWriteReq(flashWriteReq),
    .sysRst_b(sysRst_b), .coreCtrl(coreCtrl), .fetchAddr(fetchAddr), .portLatch(portLatch),
    .portOpenDrain(portOpenDrain), .weakPullupEn(weakPullupEn), .watchdogEnable(watchdogEnable),
    .watchdogTick(watchdogTick));
  srsc_far_side far_u (.clk_sys(clk_sys), .extPinLow(extPinLow), .supplyGood(supplyGood), .compLow(compLow),
    .clockStuck(clockStuck), .resetPinOut(resetPinOut), .resetPinOe(resetPinOe), .supplyAbove(supplyAbove),
    .resetPinIn(resetPinIn), .comparatorOut(comparatorOut), .clockMonitor(clockMonitor));
  //==========================================================================
  // shared tasks
  task automatic close_out();
    $display("checked %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, d, rd, err);
  endtask
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input logic [31:0] mask);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h0000_0000, rd, err);
    cmp(rd & mask, exp & mask);
  endtask
  // waits for sysRst_b to reach a level, returns the cycles taken
  task automatic wait_rst(input logic lvl, input int limit, output int n);
    n = 0;
    while (sysRst_b !== lvl && n < limit) begin
      @(posedge clk_sys);
      n++;
    end
    cmp(sysRst_b, lvl);
  endtask
  task automatic hold(input int c);
    repeat (c) @(posedge clk_sys);
  endtask
  //==========================================================================
  // scenarios
  task automatic t_power_on();
    logic [31:0] rd;
    logic err;
    int n, ticks;
    hold(30);
    cmp({sysRst_b, resetPinOe, portLatch, portOpenDrain, weakPullupEn}, {2'b01, 8'hFF, 2'b11});
    supplyGood <= 1'b1;
    wait_rst(1'b1, POR_CYC + 50, n);
    cmp({fetchAddr, resetPinOe, watchdogEnable, weakPullupEn, portOpenDrain, coreCtrl.pcClear,
         coreCtrl.clkSelInternal}, {16'h0000, 6'b011011});
    rd_chk(ADDR_RESET_SRC, 32'h0000_0002, 32'h0000_0002);
    rd_chk(ADDR_SUPPLY_CTRL, 32'h0000_00C0, 32'hFFFF_FFFF);
    ticks = 0;
    repeat (120) begin
      @(posedge clk_sys);
      ticks += (watchdogTick === 1'b1);
    end
    cmp(ticks, 10);
    apb(1'b0, 12'h000, 32'h0000_0000, rd, err);
    cmp(err, 1'b1);
    cmp(rd, 32'h0000_0000);
    $display("power-on test done");
  endtask
  task automatic t_soft();
    int n;
    wr(ADDR_RESET_SRC, 32'h0000_0012);
    wait_rst(1'b0, 10, n);
    cmp({coreCtrl.haltCpu, coreCtrl.sfrInit, coreCtrl.intDisable, coreCtrl.timerDisable,
         coreCtrl.stackPtrReset, portLatch, resetPinOe}, {5'h1F, 8'hFF, 1'b0});
    wait_rst(1'b1, 1000, n);
    rd_chk(ADDR_RESET_SRC, 32'h0000_0010, 32'hFFFF_FFFF);
    $display("software reset test done");
  endtask
  task automatic t_pin();
    int n;
    extPinLow <= 1'b1;
    hold(400);
    cmp({sysRst_b, resetPinOe}, 2'b00);
    extPinLow <= 1'b0;
    wait_rst(1'b1, 1000, n);
    rd_chk(ADDR_RESET_SRC, 32'h0000_0001, 32'hFFFF_FFFF);
    $display("pin reset test done");
  endtask
  task automatic t_comp();
    int n;
    wr(ADDR_RESET_SRC, 32'h0000_0022);
    rd_chk(ADDR_RESET_ENA, 32'h0000_0022, 32'hFFFF_FFFF);
    compLow <= 1'b1;
    wait_rst(1'b0, 10, n);
    cmp(resetPinOe, 1'b0);
    compLow <= 1'b0;
    wait_rst(1'b1, 1000, n);
    rd_chk(ADDR_RESET_SRC, 32'h0000_0020, 32'hFFFF_FFFF);
    rd_chk(ADDR_RESET_ENA, 32'h0000_0002, 32'hFFFF_FFFF);
    $display("comparator test done");
  endtask
  task automatic t_clk();
    int n;
    wr(ADDR_RESET_SRC, 32'h0000_0006);
    clockStuck <= 1'b1;
    wait_rst(1'b0, CLK_LOSS_CYC + 50, n);
    cmp(n >= CLK_LOSS_CYC - 10, 1'b1);
    cmp(resetPinOe, 1'b0);
    clockStuck <= 1'b0;
    wait_rst(1'b1, 1000, n);
    rd_chk(ADDR_RESET_SRC, 32'h0000_0004, 32'hFFFF_FFFF);
    $display("clock loss test done");
  endtask
  task automatic t_mon();
    int n;
    wr(ADDR_SUPPLY_CTRL, 32'h0000_0000);
    t_soft();
    rd_chk(ADDR_SUPPLY_CTRL, 32'h0000_0040, 32'hFFFF_FFFF);
    supplyGood <= 1'b0;
    hold(50);
    cmp(sysRst_b, 1'b1);
    supplyGood <= 1'b1;
    hold(5);
    flashWriteReq <= 1'b1;
    @(posedge clk_sys);
    flashWriteReq <= 1'b0;
    wait_rst(1'b0, 10, n);
    wait_rst(1'b1, 1000, n);
    rd_chk(ADDR_RESET_SRC, 32'h0000_0040, 32'hFFFF_FFFF);
    watchdogDisable <= 1'b1;
    hold(2);
    cmp(watchdogEnable, 1'b0);
    watchdogDisable <= 1'b0;
    watchdogTimeout <= 1'b1;
    @(posedge clk_sys);
    watchdogTimeout <= 1'b0;
    wait_rst(1'b0, 10, n);
    wait_rst(1'b1, 1000, n);
    cmp(watchdogEnable, 1'b1);
    rd_chk(ADDR_RESET_SRC, 32'h0000_0008, 32'hFFFF_FFFF);
    wr(ADDR_SUPPLY_CTRL, 32'h0000_0080);
    hold(100);
    wr(ADDR_RESET_SRC, 32'h0000_0002);
    supplyGood <= 1'b0;
    wait_rst(1'b0, 10, n);
    cmp({resetPinOut, resetPinOe}, 2'b01);
    rd_chk(ADDR_SUPPLY_CTRL, 32'h0000_0080, 32'hFFFF_FFFF);
    supplyGood <= 1'b1;
    wait_rst(1'b1, 1000, n);
    rd_chk(ADDR_RESET_SRC, 32'h0000_0002, 32'h0000_0002);
    $display("supply monitor test done");
  endtask
  //==========================================================================
  // clock, reset, sequence and watchdog
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = !clk_sys;
  end
  initial begin
    n_errors = 0; samples_checked = 0; rst_b = 1'b0;
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
    watchdogTimeout = 1'b0; flashWriteReq = 1'b0; watchdogDisable = 1'b0;
    extPinLow = 1'b0; supplyGood = 1'b0; compLow = 1'b0; clockStuck = 1'b0;
    hold(2);
    rst_b <= 1'b1;
    t_power_on();
    t_soft();
    t_pin();
    t_comp();
    t_clk();
    t_mon();
    close_out();
  end
  // whole run is near 9300 cycles; cut off well past that
  initial begin
    #2_000_000;
    n_errors++;
    close_out();
  end
endmodule
